// ### rtl/pbn_port_defines.svh
// Offsets, field positions, reset values and widths of the port nibble
`ifndef PBN_PORT_DEFINES_SVH
`define PBN_PORT_DEFINES_SVH

// ********************************
// Register offsets
// ********************************
`define PBN_OFS_PORT   8'h00
`define PBN_OFS_LATCH  8'h01
`define PBN_OFS_DIR    8'h02
`define PBN_OFS_ANSEL  8'h03
`define PBN_OFS_PUCTL  8'h04

// ********************************
// Field positions and widths
// ********************************
`define PBN_NPINS      4
`define PBN_DW         8
`define PBN_AW         8
`define PBN_PU_BIT     7
`define PBN_PIN_EINT   0
`define PBN_PIN_BE     1
`define PBN_PIN_A3     2
`define PBN_PIN_A2     3

// ********************************
// Reset values
// ********************************
`define PBN_RST_LATCH  4'h0
`define PBN_RST_DIR    4'hF
`define PBN_RST_ANSEL  4'h0
`define PBN_RST_PU_N   1'b1
`define PBN_RST_BYTE   8'h00

`endif

// ### rtl/pbn_port_pkg.sv
// Types shared by the port nibble design
package pbn_port_pkg;

  // ********************************
  // Types
  // ********************************
  typedef logic [3:0] pbn_pin_t;   // One bit per pin
  typedef logic [7:0] pbn_data_t;  // Register data
  typedef logic [7:0] pbn_addr_t;  // Register address

  // Source that drives a pin
  typedef enum logic [2:0] {
    PBN_SRC_OFF,
    PBN_SRC_LATCH,
    PBN_SRC_REMAP,
    PBN_SRC_USB,
    PBN_SRC_REFCLK,
    PBN_SRC_PMP
  } pbn_src_e;

endpackage

// ### rtl/pbn_port_io.sv
// Lower nibble of a general-purpose port with shared pin functions
`timescale 1ns/1ps
`include "pbn_port_defines.svh"

// Function
// - Direction one: input, level read back
// - Direction zero: latch drives pin, analog ignored
// - Input pull-up only while control bit cleared
// - Analog selection disables digital input path
// - Reset selects all pins analog
// - Debug mode disables all shared functions
// - Parallel port outputs override direction bit
// - Remap input when one, output when zero
// - USB and reference clock only as outputs
// - Bit zero feeds external interrupt when input
// - Parallel port functions only in large package
// - Control bit seven disables all pull-ups
// - Pull-ups off at reset and for outputs
// - Analog pins read as zero
module pbn_port_io #(
  parameter bit LARGE_PKG = 1'b1  // Parallel port pins present
) (
  input  wire logic                  CLK_SYS,
  input  wire logic                  RESETN,
  input  wire logic                  CE,
  input  wire pbn_port_pkg::pbn_addr_t ADDR,
  input  wire pbn_port_pkg::pbn_data_t WDATA,
  input  wire logic                  WR,
  input  wire logic                  RD,
  output pbn_port_pkg::pbn_data_t    RDATA,
  input  wire pbn_port_pkg::pbn_pin_t PIN_IN,
  output pbn_port_pkg::pbn_pin_t     PIN_OUT,
  output pbn_port_pkg::pbn_pin_t     PIN_OE_N,
  output pbn_port_pkg::pbn_pin_t     PIN_PULLUP,
  output pbn_port_pkg::pbn_pin_t     PIN_ANALOG,
  input  wire logic                  IN_CIRCUIT_DEBUG_MODE,
  input  wire logic                  PARALLEL_BYTE_ENABLE_EN,
  input  wire logic                  PARALLEL_BYTE_ENABLE_OUT,
  input  wire logic                  PARALLEL_ADDRESS_TWO_EN,
  input  wire logic                  PARALLEL_ADDRESS_TWO_OUT,
  input  wire logic                  PARALLEL_ADDRESS_THREE_EN,
  input  wire logic                  PARALLEL_ADDRESS_THREE_OUT,
  input  wire logic                  USB_XCVR_EN,
  input  wire logic                  USB_XCVR_MINUS_OUT,
  input  wire logic                  USB_XCVR_PLUS_OUT,
  input  wire logic                  REFERENCE_CLOCK_EN,
  input  wire logic                  REFERENCE_CLOCK_OUT,
  input  wire pbn_port_pkg::pbn_pin_t REMAP_OUT_EN,
  input  wire pbn_port_pkg::pbn_pin_t REMAP_OUT,
  output pbn_port_pkg::pbn_pin_t     REMAP_IN,
  output logic                       EXTERNAL_INTERRUPT_ZERO_IN
);
  import pbn_port_pkg::*;

  // ********************************
  // Elaboration checks
  // ********************************
  if (`PBN_NPINS != 4) begin : g_bad_pins
    $error("Port nibble needs exactly four pins");
  end
  if (`PBN_PU_BIT >= `PBN_DW) begin : g_bad_pu
    $error("Pull-up bit must fit the data width");
  end

  // ********************************
  // Functions
  // ********************************

  // Choose what drives one pin, highest priority first
  function automatic pbn_src_e pick_src(
    input logic dbg,    // Debug owns the pin
    input logic pmp,    // Parallel port claims it
    input logic dir,    // Direction bit
    input logic usb,    // USB output selected here
    input logic refc,   // Reference clock selected here
    input logic remap   // Remap output selected here
  );
    pbn_src_e s;
    s = PBN_SRC_LATCH;
    if (dbg) begin
      s = PBN_SRC_OFF;
    end else if (pmp) begin
      s = PBN_SRC_PMP;
    end else if (dir) begin
      s = PBN_SRC_OFF;
    end else if (usb) begin
      s = PBN_SRC_USB;
    end else if (refc) begin
      s = PBN_SRC_REFCLK;
    end else if (remap) begin
      s = PBN_SRC_REMAP;
    end
    return s;
  endfunction

  // Level a pin carries for a given source
  function automatic logic src_level(
    input pbn_src_e s,
    input logic     lat,    // Output latch bit
    input logic     pmpv,   // Parallel port value
    input logic     usbv,   // USB output value
    input logic     refv,   // Reference clock value
    input logic     rpv     // Remap output value
  );
    logic v;
    v = 1'b0;
    case (s)
      PBN_SRC_LATCH:  v = lat;
      PBN_SRC_PMP:    v = pmpv;
      PBN_SRC_USB:    v = usbv;
      PBN_SRC_REFCLK: v = refv;
      PBN_SRC_REMAP:  v = rpv;
      PBN_SRC_OFF:    v = 1'b0;        // Driver off
      default:        v = 1'b0;        // Unused codes
    endcase
    return v;
  endfunction

  // ********************************
  // Registers
  // ********************************
  pbn_pin_t  latch;        // Output latch
  pbn_pin_t  dir;          // Direction, one is input
  pbn_pin_t  digital_sel;  // One per pin, one is digital
  logic      pullup_disable_n; // Shared pull-up control
  pbn_pin_t  port_level;   // Sampled digital levels

  // ********************************
  // Bus decode
  // ********************************
  wire logic hit_port  = (ADDR == `PBN_OFS_PORT);
  wire logic hit_latch = (ADDR == `PBN_OFS_LATCH);
  wire logic hit_dir   = (ADDR == `PBN_OFS_DIR);
  wire logic hit_ansel = (ADDR == `PBN_OFS_ANSEL);
  wire logic hit_puctl = (ADDR == `PBN_OFS_PUCTL);

  // Port and latch writes both load the latch
  wire logic wr_latch = WR & (hit_port | hit_latch);
  wire logic wr_dir   = WR & hit_dir;
  wire logic wr_ansel = WR & hit_ansel;
  wire logic wr_puctl = WR & hit_puctl;

  // Read multiplexer, unmapped reads give zero
  wire pbn_data_t rd_mux =
    hit_port  ? {4'h0, port_level}  :
    hit_latch ? {4'h0, latch}       :
    hit_dir   ? {4'h0, dir}         :
    hit_ansel ? {4'h0, digital_sel} :
    hit_puctl ? {pullup_disable_n, 7'h00} :
    8'h00;

  // Read data only in the cycle after the strobe
  wire pbn_data_t next_rdata = RD ? rd_mux : 8'h00;

  // ********************************
  // Pin function claims
  // ********************************
  wire logic dbg = IN_CIRCUIT_DEBUG_MODE;

  // Parallel port claims exist only in the large package
  wire pbn_pin_t pmp_claim = LARGE_PKG ? {
    PARALLEL_ADDRESS_TWO_EN,
    PARALLEL_ADDRESS_THREE_EN,
    PARALLEL_BYTE_ENABLE_EN,
    1'b0} : 4'h0;

  // Parallel port values per pin
  wire pbn_pin_t pmp_val = {
    PARALLEL_ADDRESS_TWO_OUT,
    PARALLEL_ADDRESS_THREE_OUT,
    PARALLEL_BYTE_ENABLE_OUT,
    1'b0};

  // USB outputs sit on pins two and three
  wire pbn_pin_t usb_claim = {USB_XCVR_EN, USB_XCVR_EN, 2'b00};
  wire pbn_pin_t usb_val   = {USB_XCVR_PLUS_OUT,
                              USB_XCVR_MINUS_OUT, 2'b00};

  // Reference clock sits on pin two
  wire pbn_pin_t ref_claim = {1'b0, REFERENCE_CLOCK_EN, 2'b00};
  wire pbn_pin_t ref_val   = {1'b0, REFERENCE_CLOCK_OUT, 2'b00};

  // ********************************
  // Per-pin next values
  // ********************************
  pbn_pin_t next_out;      // Pin level when driven
  pbn_pin_t next_oe_n;     // Low while driving
  pbn_pin_t next_pullup;   // Weak pull-up on
  pbn_pin_t next_analog;   // Analog path selected
  pbn_pin_t next_level;    // Digital input level
  pbn_pin_t next_remap_in; // Remap input level

  for (genvar i = 0; i < `PBN_NPINS; i++) begin : g_pin
    // Selected source for this pin
    wire pbn_src_e src = pick_src(dbg, pmp_claim[i], dir[i],
      usb_claim[i], ref_claim[i], REMAP_OUT_EN[i]);

    // Digital input path alive only when not analog
    wire logic dig_ok = digital_sel[i] & ~dbg;

    assign next_out[i] = src_level(src, latch[i], pmp_val[i],
      usb_val[i], ref_val[i], REMAP_OUT[i]);

    // Driver on for any source but off
    assign next_oe_n[i] = (src == PBN_SRC_OFF);

    // Pull-up only for undriven inputs with control clear
    assign next_pullup[i] = dir[i] & ~pullup_disable_n
                            & ~dbg & next_oe_n[i];

    // Analog path per pin, off in debug
    assign next_analog[i] = ~digital_sel[i] & ~dbg;

    // Analog pins read as zero
    assign next_level[i] = dig_ok & PIN_IN[i];

    // Remap input only while the pin is an input
    assign next_remap_in[i] = dig_ok & dir[i] & PIN_IN[i];
  end

  // External interrupt from bit zero while it is an input
  wire logic next_eint = next_remap_in[`PBN_PIN_EINT];

  // ********************************
  // Control registers
  // ********************************

  // Software-written state
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      latch            <= `PBN_RST_LATCH;
      dir              <= `PBN_RST_DIR;
      digital_sel      <= `PBN_RST_ANSEL;
      pullup_disable_n <= `PBN_RST_PU_N;
    end else if (CE) begin
      if (wr_latch) begin
        latch <= WDATA[3:0];
      end
      if (wr_dir) begin
        dir <= WDATA[3:0];
      end
      if (wr_ansel) begin
        digital_sel <= WDATA[3:0];
      end
      if (wr_puctl) begin
        pullup_disable_n <= WDATA[`PBN_PU_BIT];
      end
    end
  end

  // ********************************
  // Read data
  // ********************************

  // Registered read answer
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      RDATA <= `PBN_RST_BYTE;
    end else if (CE) begin
      RDATA <= next_rdata;
    end
  end

  // ********************************
  // Pin and peripheral outputs
  // ********************************

  // Pin drivers and pad controls
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      PIN_OUT    <= 4'h0;
      PIN_OE_N   <= 4'hF;                   // Inputs at reset
      PIN_PULLUP <= 4'h0;
      PIN_ANALOG <= 4'hF;
    end else if (CE) begin
      PIN_OUT    <= next_out;
      PIN_OE_N   <= next_oe_n;
      PIN_PULLUP <= next_pullup;
      PIN_ANALOG <= next_analog;
    end
  end

  // Sampled input levels toward software and peripherals
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      port_level                 <= 4'h0;
      REMAP_IN                   <= 4'h0;
      EXTERNAL_INTERRUPT_ZERO_IN <= 1'b0;
    end else if (CE) begin
      port_level                 <= next_level;
      REMAP_IN                   <= next_remap_in;
      EXTERNAL_INTERRUPT_ZERO_IN <= next_eint;
    end
  end

endmodule

// ### bench/pbn_board_model.sv
// Board circuitry on the four pads: drivers, weak pull-ups, floating lines
`timescale 1ns/1ps
module pbn_board_model (
  input  wire logic                   clk,
  input  wire pbn_port_pkg::pbn_pin_t pin_out,
  input  wire pbn_port_pkg::pbn_pin_t pin_oe_n,
  input  wire pbn_port_pkg::pbn_pin_t pin_pullup,
  input  wire pbn_port_pkg::pbn_pin_t ext_drive,
  input  wire pbn_port_pkg::pbn_pin_t ext_en,
  output pbn_port_pkg::pbn_pin_t      pad
);
  import pbn_port_pkg::*;
  pbn_pin_t last;  // Last pad level, inverted when floating
  // Device driver first, then pull-up, then board driver, else drift
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (!pin_oe_n[i]) pad[i] = pin_out[i];
      else if (pin_pullup[i]) pad[i] = 1'b1;
      else if (ext_en[i]) pad[i] = ext_drive[i];
      else pad[i] = ~last[i];
    end
  end
  always_ff @(posedge clk) last <= pad;
endmodule

// ### bench/pbn_port_monitor.sv
// Concurrent checks on the port nibble pins
`timescale 1ns/1ps
module pbn_port_monitor #(
  parameter bit LARGE_PKG = 1'b1
) (
  input wire logic                   CLK_SYS,
  input wire logic                   RESETN,
  input wire logic                   CE,
  input wire logic                   IN_CIRCUIT_DEBUG_MODE,
  input wire logic                   PARALLEL_BYTE_ENABLE_EN,
  input wire logic                   PARALLEL_BYTE_ENABLE_OUT,
  input wire logic                   USB_XCVR_EN,
  input wire logic                   USB_XCVR_MINUS_OUT,
  input wire logic                   PARALLEL_ADDRESS_THREE_EN,
  input wire logic                   EXTERNAL_INTERRUPT_ZERO_IN,
  input wire pbn_port_pkg::pbn_pin_t PIN_IN,
  input wire pbn_port_pkg::pbn_pin_t PIN_OUT,
  input wire pbn_port_pkg::pbn_pin_t PIN_OE_N,
  input wire pbn_port_pkg::pbn_pin_t PIN_PULLUP,
  input wire pbn_port_pkg::pbn_pin_t PIN_ANALOG,
  input wire pbn_port_pkg::pbn_pin_t REMAP_IN,
  input wire pbn_port_pkg::pbn_pin_t REMAP_OUT_EN,
  input wire pbn_port_pkg::pbn_pin_t REMAP_OUT
);
  default clocking @(posedge CLK_SYS); endclocking
  wire dbg = IN_CIRCUIT_DEBUG_MODE;  // Debug owns all pads
  sequence s_live; CE && !dbg; endsequence
  reset_state_a: assert property ($rose(RESETN) |-> PIN_ANALOG == 4'hF &&
    PIN_PULLUP == 4'h0 && PIN_OE_N == 4'hF) else $error("reset pin state wrong");
  pullup_out_a: assert property (disable iff (!RESETN)
    (PIN_PULLUP & ~PIN_OE_N) == 4'h0) else $error("pull-up on driven pin");
  debug_free_a: assert property (disable iff (!RESETN) CE && dbg |=>
    PIN_OE_N == 4'hF && REMAP_IN == 4'h0 && !EXTERNAL_INTERRUPT_ZERO_IN)
    else $error("debug mode left a function active");
  pmp_claim_a: assert property (disable iff (!RESETN) s_live ##0 LARGE_PKG
    && PARALLEL_BYTE_ENABLE_EN |=> !PIN_OE_N[1] && PIN_OUT[1] == $past(PARALLEL_BYTE_ENABLE_OUT))
    else $error("byte enable did not claim pin");
  analog_gate_a: assert property (disable iff (!RESETN)
    (REMAP_IN & PIN_ANALOG) == 4'h0) else $error("analog pin reached input");
  eint_follow_a: assert property (disable iff (!RESETN) s_live ##1 PIN_OE_N[0]
    && !PIN_ANALOG[0] |-> EXTERNAL_INTERRUPT_ZERO_IN == $past(PIN_IN[0]))
    else $error("interrupt input does not follow pin");
  usb_gate_a: assert property (disable iff (!RESETN) s_live ##0 USB_XCVR_EN
    && !PARALLEL_ADDRESS_THREE_EN |=> PIN_OE_N[2] || PIN_OUT[2] == $past(USB_XCVR_MINUS_OUT))
    else $error("usb minus missing on pin");
  remap_out_a: assert property (disable iff (!RESETN) s_live ##0 REMAP_OUT_EN[0]
    |=> PIN_OE_N[0] || PIN_OUT[0] == $past(REMAP_OUT[0])) else $error("remap output missing");
endmodule
bind pbn_port_io pbn_port_monitor #(.LARGE_PKG(LARGE_PKG)) i_pbn_port_monitor (.CLK_SYS,
  .RESETN, .CE, .IN_CIRCUIT_DEBUG_MODE, .PARALLEL_BYTE_ENABLE_EN, .PARALLEL_BYTE_ENABLE_OUT,
  .USB_XCVR_EN, .USB_XCVR_MINUS_OUT, .PARALLEL_ADDRESS_THREE_EN, .EXTERNAL_INTERRUPT_ZERO_IN,
  .PIN_IN, .PIN_OUT, .PIN_OE_N, .PIN_PULLUP, .PIN_ANALOG, .REMAP_IN, .REMAP_OUT_EN, .REMAP_OUT);

// ### bench/tb_top.sv
// Register-level tests of the port nibble
`timescale 1ns/1ps
`include "pbn_port_defines.svh"
module tb_top;
  import pbn_port_pkg::*;
  logic      clk = 1'b0, resetn = 1'b0, wr_s = 1'b0, rd_s = 1'b0, dbg = 1'b0, eint;
  logic      be_en = 1'b0, be_o = 1'b0, a2_en = 1'b0, a2_o = 1'b0, a3_en = 1'b0, a3_o = 1'b0;
  logic      usb_en = 1'b0, vm = 1'b0, vp = 1'b0, rf_en = 1'b0, rf_o = 1'b0;
  pbn_addr_t addr = 8'h00;
  pbn_data_t wdata = 8'h00, rdata;
  pbn_pin_t  ro_en = 4'h0, ro = 4'h0, ext = 4'hF, ext_en = 4'hF;
  pbn_pin_t  pad, pout, poe, ppu, pan, rin;
  int        err_count = 0, tests_run = 0;
  always #2.5 clk = ~clk;
  pbn_port_io i_pbn_port_io (.CLK_SYS(clk), .RESETN(resetn), .CE(1'b1), .ADDR(addr),
    .WDATA(wdata), .WR(wr_s), .RD(rd_s), .RDATA(rdata), .PIN_IN(pad), .PIN_OUT(pout),
    .PIN_OE_N(poe), .PIN_PULLUP(ppu), .PIN_ANALOG(pan), .IN_CIRCUIT_DEBUG_MODE(dbg),
    .PARALLEL_BYTE_ENABLE_EN(be_en), .PARALLEL_BYTE_ENABLE_OUT(be_o),
    .PARALLEL_ADDRESS_TWO_EN(a2_en), .PARALLEL_ADDRESS_TWO_OUT(a2_o),
    .PARALLEL_ADDRESS_THREE_EN(a3_en), .PARALLEL_ADDRESS_THREE_OUT(a3_o),
    .USB_XCVR_EN(usb_en), .USB_XCVR_MINUS_OUT(vm), .USB_XCVR_PLUS_OUT(vp),
    .REFERENCE_CLOCK_EN(rf_en), .REFERENCE_CLOCK_OUT(rf_o), .REMAP_OUT_EN(ro_en),
    .REMAP_OUT(ro), .REMAP_IN(rin), .EXTERNAL_INTERRUPT_ZERO_IN(eint));
  pbn_board_model i_pbn_board_model (.clk(clk), .pin_out(pout), .pin_oe_n(poe),
    .pin_pullup(ppu), .ext_drive(ext), .ext_en(ext_en), .pad(pad));
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input pbn_addr_t a, input pbn_data_t d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input pbn_addr_t a, input pbn_data_t e);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    chk("rdata", rdata, e);
    @(posedge clk);
    #1;
    chk("rdata_idle", rdata, 8'h00);
  endtask
  task automatic st();
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    rd(`PBN_OFS_DIR, 8'h0F);
    rd(`PBN_OFS_ANSEL, 8'h00);
    rd(`PBN_OFS_PORT, 8'h00);
    rd(`PBN_OFS_PUCTL, 8'h80);
    rd(8'h10, 8'h00);
    chk("pullup", ppu, 4'h0);
    chk("analog", pan, 4'hF);
    wr(`PBN_OFS_ANSEL, 8'h0E);
    st();
    rd(`PBN_OFS_PORT, 8'h0E);
    chk("analog", pan, 4'h1);
    chk("eint", eint, 1'b0);
    wr(`PBN_OFS_ANSEL, 8'h0F);
    st();
    chk("eint", eint, 1'b1);
    chk("analog", pan, 4'h0);
    ext_en <= 4'h0;
    wr(`PBN_OFS_PUCTL, 8'h00);
    st();
    chk("pullup", ppu, 4'hF);
    rd(`PBN_OFS_PORT, 8'h0F);
    rd(`PBN_OFS_PUCTL, 8'h00);
    wr(`PBN_OFS_ANSEL, 8'h00);
    wr(`PBN_OFS_LATCH, 8'h05);
    wr(`PBN_OFS_DIR, 8'h0C);
    st();
    chk("oe_n", poe, 4'hC);
    chk("out", pout & 4'h3, 4'h1);
    chk("pullup", ppu, 4'hC);
    chk("analog", pan, 4'hF);
    ro_en <= 4'h1;
    st();
    chk("out", pout & 4'h1, 4'h0);
    ro_en <= 4'h0;
    ext_en <= 4'hF;
    wr(`PBN_OFS_PUCTL, 8'h80);
    wr(`PBN_OFS_DIR, 8'h0F);
    {be_en, be_o, a3_en, a3_o, a2_en, a2_o} <= 6'h3E;
    st();
    chk("oe_n", poe, 4'h1);
    chk("out", pout & 4'hE, 4'h6);
    {be_en, a3_en, a2_en, usb_en, vm, rf_en, rf_o} <= 7'h0F;
    st();
    chk("oe_n", poe, 4'hF);
    wr(`PBN_OFS_DIR, 8'h00);
    st();
    chk("out", pout & 4'hC, 4'h4);
    usb_en <= 1'b0;
    vm <= 1'b0;
    st();
    chk("out", pout & 4'h4, 4'h4);
    wr(`PBN_OFS_PORT, 8'h0A);
    st();
    chk("out", pout & 4'hB, 4'hA);
    rd(`PBN_OFS_LATCH, 8'h0A);
    dbg <= 1'b1;
    st();
    chk("oe_n", poe, 4'hF);
    chk("analog", pan, 4'h0);
    dbg <= 1'b0;
    ext <= 4'h5;
    wr(`PBN_OFS_ANSEL, 8'h0F);
    wr(`PBN_OFS_DIR, 8'h0F);
    st();
    chk("remap_in", rin, 4'h5);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rd(`PBN_OFS_ANSEL, 8'h00);
    rd(`PBN_OFS_LATCH, 8'h00);
    chk("analog", pan, 4'hF);
    chk("pullup", ppu, 4'h0);
    results();
  end
endmodule
